// ==== hdl/drt_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface drt_link_if;
  logic [2:0] clk_sel;
  logic [7:0] constant;
  logic cnt_we;
  logic [7:0] cnt_wdata;
  logic [7:0] count;
  logic match;
  logic cbr_go;
  logic self_req;
  logic long_pitch;
  logic [1:0] wait_cnt;
  logic ras_n;
  logic cas_n;
  logic idle;
  logic in_self;
  logic done;
  modport ctl (output clk_sel, constant, cnt_we, cnt_wdata, cbr_go, self_req, long_pitch,
               wait_cnt, input count, match, ras_n, cas_n, idle, in_self, done);
  modport tmr (input clk_sel, constant, cnt_we, cnt_wdata, output count, match);
  modport seq (input cbr_go, self_req, long_pitch, wait_cnt,
               output ras_n, cas_n, idle, in_self, done);
endinterface : drt_link_if
`default_nettype wire

// ==== hdl/drt_pkg.sv ====
package drt_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_TCSR = 8'h04;
  localparam logic [7:0] ADR_COUNT = 8'h08;
  localparam logic [7:0] ADR_CONST = 8'h0c;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADR_IRQ_EN = 8'h18;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_WAIT_LO = 2;
  localparam int CTRL_PITCH_BIT = 4;
  localparam int IRQ_MATCH_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam int IRQ_W = 2;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CONST = 8'hff;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [2:0] RST_CLK_SEL = 3'h0;
  // ---------------------------------------------------------------
  // timing counts in clk_i cycles and prescaler width in bits
  // ---------------------------------------------------------------
  localparam logic [2:0] CAS_LEAD_CYC = 3'h1;
  localparam logic [2:0] RAS_LOW_CYC = 3'h2;
  localparam int PRESCALE_W = 12;
  // ---------------------------------------------------------------
  // bus cycle kinds seen while a refresh is wanted
  // ---------------------------------------------------------------
  localparam logic [1:0] KIND_EXT_RD = 2'h0;
  localparam logic [1:0] KIND_EXT_WR = 2'h1;
  localparam logic [1:0] KIND_DRAM = 2'h2;
  localparam logic [1:0] KIND_ONCHIP = 2'h3;
endpackage : drt_pkg

// ==== hdl/drt_strobe.sv ====
`timescale 1ns/1ps
`default_nettype none
module drt_strobe (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control side
  drt_link_if.seq lk
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_CAS, ST_RAS, ST_WAIT, ST_SELF_CAS, ST_SELF, ST_SELF_EXIT
  } drt_state_t;

  drt_state_t st_q;
  logic [2:0] cnt_q;
  logic ras_n_q;
  logic cas_n_q;
  logic done_q;

  // ---------------------------------------------------------------
  // cas-before-ras and self-refresh sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 3'h0;
      ras_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (lk.self_req) begin
            cas_n_q <= 1'b0;
            cnt_q <= drt_pkg::CAS_LEAD_CYC;
            st_q <= ST_SELF_CAS;
          end else if (lk.cbr_go) begin
            cas_n_q <= 1'b0;
            cnt_q <= drt_pkg::CAS_LEAD_CYC;
            st_q <= ST_CAS;
          end
        end
        ST_CAS: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            ras_n_q <= 1'b0;
            cnt_q <= drt_pkg::RAS_LOW_CYC;
            st_q <= ST_RAS;
          end
        end
        ST_RAS: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            if (lk.long_pitch && lk.wait_cnt != 2'h0) begin
              cnt_q <= {1'b0, lk.wait_cnt};
              st_q <= ST_WAIT;
            end else begin
              ras_n_q <= 1'b1;
              cas_n_q <= 1'b1;
              done_q <= 1'b1;
              st_q <= ST_IDLE;
            end
          end
        end
        ST_WAIT: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            ras_n_q <= 1'b1;
            cas_n_q <= 1'b1;
            done_q <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        ST_SELF_CAS: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            ras_n_q <= 1'b0;
            st_q <= ST_SELF;
          end
        end
        ST_SELF: begin
          if (!lk.self_req) begin
            ras_n_q <= 1'b1;
            cnt_q <= drt_pkg::CAS_LEAD_CYC;
            st_q <= ST_SELF_EXIT;
          end
        end
        ST_SELF_EXIT: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            cas_n_q <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        default: begin
          ras_n_q <= 1'b1;
          cas_n_q <= 1'b1;
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign lk.ras_n = ras_n_q;
  assign lk.cas_n = cas_n_q;
  assign lk.idle = (st_q == ST_IDLE);
  assign lk.in_self = (st_q == ST_SELF_CAS) || (st_q == ST_SELF) || (st_q == ST_SELF_EXIT);
  assign lk.done = done_q;
endmodule : drt_strobe
`default_nettype wire

// ==== hdl/drt_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module drt_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control side
  drt_link_if.tmr lk
);
  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  logic [drt_pkg::PRESCALE_W-1:0] pre_q;
  logic tick;

  function automatic logic tap(input logic [2:0] sel, input logic [11:0] p);
    case (sel)
      3'h1: tap = &p[0:0];
      3'h2: tap = &p[2:0];
      3'h3: tap = &p[4:0];
      3'h4: tap = &p[6:0];
      3'h5: tap = &p[8:0];
      3'h6: tap = &p[10:0];
      3'h7: tap = &p[11:0];
      default: tap = 1'b0;
    endcase
  endfunction : tap

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 12'h001;
    end
  end

  assign tick = tap(lk.clk_sel, pre_q);

  // ---------------------------------------------------------------
  // counter and compare
  // ---------------------------------------------------------------
  logic [7:0] count_q;
  logic match_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= drt_pkg::RST_COUNT;
      match_q <= 1'b0;
    end else if (lk.cnt_we) begin
      count_q <= lk.cnt_wdata;
      match_q <= 1'b0;
    end else if (tick) begin
      if (count_q == lk.constant) begin
        count_q <= 8'h00;
        match_q <= 1'b1;
      end else begin
        count_q <= count_q + 8'h01;
        match_q <= 1'b0;
      end
    end else begin
      match_q <= 1'b0;
    end
  end

  assign lk.count = count_q;
  assign lk.match = match_q;
endmodule : drt_timer
`default_nettype wire

// ==== hdl/drt_top.sv ====
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module drt_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // bus cycle in progress
  input wire logic bus_busy_i,
  input wire logic [1:0] bus_kind_i,
  input wire logic page_ras_low_i,
  // dram strobes and status
  output logic dram_ras_n_o,
  output logic dram_cas_n_o,
  output logic ras_release_o,
  output logic self_refresh_o,
  // interrupt
  output logic irq_o
);
  drt_link_if lk ();

  // ---------------------------------------------------------------
  // sub blocks
  // ---------------------------------------------------------------
  drt_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lk(lk.tmr)
  );

  drt_strobe u_strobe (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lk(lk.seq)
  );

  // ---------------------------------------------------------------
  // wishbone handshake
  // ---------------------------------------------------------------
  logic ack_q;
  logic req;
  logic wr_now;
  logic wr_lo;

  assign req = wb_cyc_i && wb_stb_i;
  assign wr_now = req && wb_we_i && ack_q;
  assign wr_lo = wr_now && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction : hit

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  logic refresh_enable_bit_q;
  logic refresh_mode_sel_q;
  logic [1:0] refresh_wait_count_q;
  logic area1_long_read_pitch_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refresh_enable_bit_q <= 1'b0;
      refresh_mode_sel_q <= 1'b0;
      refresh_wait_count_q <= 2'h0;
      area1_long_read_pitch_q <= 1'b0;
    end else if (wr_lo && hit(wb_adr_i, drt_pkg::ADR_CTRL)) begin
      refresh_enable_bit_q <= wb_dat_i[drt_pkg::CTRL_EN_BIT];
      refresh_mode_sel_q <= wb_dat_i[drt_pkg::CTRL_MODE_BIT];
      refresh_wait_count_q <= wb_dat_i[drt_pkg::CTRL_WAIT_LO +: 2];
      area1_long_read_pitch_q <= wb_dat_i[drt_pkg::CTRL_PITCH_BIT];
    end
  end

  // ---------------------------------------------------------------
  // clock select and constant
  // ---------------------------------------------------------------
  logic [2:0] counter_clock_select_q;
  logic [7:0] refresh_constant_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_clock_select_q <= drt_pkg::RST_CLK_SEL;
    end else if (wr_lo && hit(wb_adr_i, drt_pkg::ADR_TCSR)) begin
      counter_clock_select_q <= wb_dat_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refresh_constant_q <= drt_pkg::RST_CONST;
    end else if (wr_lo && hit(wb_adr_i, drt_pkg::ADR_CONST)) begin
      refresh_constant_q <= wb_dat_i[7:0];
    end
  end

  assign lk.clk_sel = counter_clock_select_q;
  assign lk.constant = refresh_constant_q;
  assign lk.cnt_we = wr_lo && hit(wb_adr_i, drt_pkg::ADR_COUNT);
  assign lk.cnt_wdata = wb_dat_i[7:0];
  assign lk.long_pitch = area1_long_read_pitch_q;
  assign lk.wait_cnt = refresh_wait_count_q;

  // ---------------------------------------------------------------
  // refresh request and contention
  // ---------------------------------------------------------------
  logic cbr_mode;
  logic self_mode;
  logic pend_q;
  logic cbr_ok;
  logic self_ok;
  logic go;

  assign cbr_mode = refresh_enable_bit_q && !refresh_mode_sel_q;
  assign self_mode = refresh_enable_bit_q && refresh_mode_sel_q;

  function automatic logic may_overlap(input logic self, input logic [1:0] kind);
    case (kind)
      drt_pkg::KIND_EXT_RD: may_overlap = 1'b1;
      drt_pkg::KIND_EXT_WR: may_overlap = self;
      drt_pkg::KIND_DRAM: may_overlap = 1'b0;
      drt_pkg::KIND_ONCHIP: may_overlap = 1'b1;
      default: may_overlap = 1'b0;
    endcase
  endfunction : may_overlap

  assign cbr_ok = !bus_busy_i || may_overlap(1'b0, bus_kind_i);
  assign self_ok = !bus_busy_i || may_overlap(1'b1, bus_kind_i);
  assign go = pend_q && lk.idle && cbr_ok && !page_ras_low_i && cbr_mode;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
    end else if (lk.match && cbr_mode) begin
      pend_q <= 1'b1;
    end else if (go || !cbr_mode) begin
      pend_q <= 1'b0;
    end
  end

  assign lk.cbr_go = go;
  assign lk.self_req = self_mode && (lk.in_self || self_ok);

  // ---------------------------------------------------------------
  // pin and status flops
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ras_release_o <= 1'b0;
      self_refresh_o <= 1'b0;
    end else begin
      ras_release_o <= pend_q || self_mode;
      self_refresh_o <= lk.in_self;
    end
  end

  assign dram_ras_n_o = lk.ras_n;
  assign dram_cas_n_o = lk.cas_n;

  // ---------------------------------------------------------------
  // interrupt status, clear and enable
  // ---------------------------------------------------------------
  logic [drt_pkg::IRQ_W-1:0] irq_stat_q;
  logic [drt_pkg::IRQ_W-1:0] irq_en_q;
  logic [drt_pkg::IRQ_W-1:0] irq_set;
  logic [drt_pkg::IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[drt_pkg::IRQ_MATCH_BIT] = lk.match && !refresh_enable_bit_q;
    irq_set[drt_pkg::IRQ_DONE_BIT] = lk.done;
  end

  assign irq_clr = (wr_lo && hit(wb_adr_i, drt_pkg::ADR_IRQ_CLR)) ?
                   wb_dat_i[drt_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_q <= '0;
    end else if (wr_lo && hit(wb_adr_i, drt_pkg::ADR_IRQ_EN)) begin
      irq_en_q <= wb_dat_i[drt_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_en_q);
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit(wb_adr_i, drt_pkg::ADR_CTRL)) begin
      rd_d[drt_pkg::CTRL_EN_BIT] = refresh_enable_bit_q;
      rd_d[drt_pkg::CTRL_MODE_BIT] = refresh_mode_sel_q;
      rd_d[drt_pkg::CTRL_WAIT_LO +: 2] = refresh_wait_count_q;
      rd_d[drt_pkg::CTRL_PITCH_BIT] = area1_long_read_pitch_q;
    end else if (hit(wb_adr_i, drt_pkg::ADR_TCSR)) begin
      rd_d[2:0] = counter_clock_select_q;
    end else if (hit(wb_adr_i, drt_pkg::ADR_COUNT)) begin
      rd_d[7:0] = lk.count;
    end else if (hit(wb_adr_i, drt_pkg::ADR_CONST)) begin
      rd_d[7:0] = refresh_constant_q;
    end else if (hit(wb_adr_i, drt_pkg::ADR_IRQ_STAT)) begin
      rd_d[drt_pkg::IRQ_W-1:0] = irq_stat_q;
    end else if (hit(wb_adr_i, drt_pkg::ADR_IRQ_EN)) begin
      rd_d[drt_pkg::IRQ_W-1:0] = irq_en_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
    end else begin
      wb_dat_o <= rd_d;
      wb_ack_o <= req && !ack_q;
    end
  end
endmodule : drt_top
`default_nettype wire

// ==== test/drt_dram_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// dram strobe watcher
// ----
module drt_dram_model (
  // strobes
  input wire logic clk_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  // observations
  output var int cbr_cnt,
  output var int low_len,
  output var int bad_cnt,
  output var logic in_self
);
  int run;
  logic ras_q;
  initial begin
    cbr_cnt = 0; low_len = 0; bad_cnt = 0; in_self = 1'b0; run = 0; ras_q = 1'b1;
  end
  always @(posedge clk_i) begin
    ras_q <= ras_n_i;
    if (!ras_n_i) run <= run + 1;
    if (!ras_n_i && ras_q && cas_n_i) bad_cnt <= bad_cnt + 1;
    if (run > 16) in_self <= 1'b1;
    if (ras_n_i && !ras_q) begin
      if (run <= 16) cbr_cnt <= cbr_cnt + 1;
      low_len <= run;
      run <= 0;
      in_self <= 1'b0;
    end
  end
endmodule : drt_dram_model
`default_nettype wire

// ==== test/drt_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// strobe and bus checks at the top ports
// ----
module drt_properties (
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic bus_busy_i,
  input wire logic [1:0] bus_kind_i,
  input wire logic page_ras_low_i,
  // strobes and status
  input wire logic dram_ras_n_o,
  input wire logic dram_cas_n_o,
  input wire logic self_refresh_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_rst;
    disable iff (1'b0) rst_i |=> !wb_ack_o && dram_ras_n_o && dram_cas_n_o && !irq_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_cbr_order; $fell(dram_ras_n_o) |-> !dram_cas_n_o && !$past(dram_cas_n_o); endproperty
  a_cbr_order: assert property (p_cbr_order) else $error("ras before cas");
  property p_cas_low; !dram_ras_n_o |-> !dram_cas_n_o; endproperty
  a_cas_low: assert property (p_cas_low) else $error("cas high in refresh");
  property p_exit; $rose(dram_ras_n_o) |-> ##[0:1] dram_cas_n_o; endproperty
  a_exit: assert property (p_exit) else $error("cas not released");
  property p_cbr_bus;
    $fell(dram_cas_n_o) && !self_refresh_o
      |-> !$past(bus_busy_i) || $past(bus_kind_i) == 2'h0 || $past(bus_kind_i) == 2'h3;
  endproperty
  a_cbr_bus: assert property (p_cbr_bus) else $error("refresh in blocked cycle");
  property p_dram;
    $fell(dram_cas_n_o) |-> !$past(bus_busy_i) || $past(bus_kind_i) != 2'h2;
  endproperty
  a_dram: assert property (p_dram) else $error("refresh in dram cycle");
  property p_page; $fell(dram_cas_n_o) && !self_refresh_o |-> !$past(page_ras_low_i); endproperty
  a_page: assert property (p_page) else $error("refresh while ras held");
  c_cbr: cover property ($fell(dram_ras_n_o) && !self_refresh_o);
  c_self: cover property ($rose(self_refresh_o));
  c_irq: cover property ($rose(irq_o));
endmodule : drt_properties
bind drt_top drt_properties chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .bus_busy_i, .bus_kind_i, .page_ras_low_i, .dram_ras_n_o, .dram_cas_n_o,
  .self_refresh_o, .irq_o);
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic bus_busy_i = 0, page_ras_low_i = 0;
  logic [1:0] bus_kind_i = 2'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, dram_ras_n_o, dram_cas_n_o, ras_release_o, self_refresh_o, irq_o;
  int miscompares = 0, checks_done = 0, c0, n;
  int cbr_cnt, low_len, bad_cnt;
  logic in_self;
  logic [7:0] ra[6] = '{8'h0c, 8'h08, 8'h00, 8'h18, 8'h10, 8'h1c};
  logic [7:0] rw[6] = '{8'hab, 8'h5a, 8'h1c, 8'h01, 8'h03, 8'hff};
  logic [7:0] re[6] = '{8'hab, 8'h5a, 8'h1c, 8'h01, 8'h00, 8'h00};
  logic [2:0] bk[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
  always #4 clk_i = ~clk_i;
  drt_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .bus_busy_i, .bus_kind_i, .page_ras_low_i,
    .dram_ras_n_o, .dram_cas_n_o, .ras_release_o, .self_refresh_o, .irq_o);
  drt_dram_model mem_u (.clk_i, .ras_n_i(dram_ras_n_o), .cas_n_i(dram_cas_n_o),
    .cbr_cnt, .low_len, .bad_cnt, .in_self);
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s exp %h got %h", w, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= 4'hf;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1);
    chk("ack cycles", 2, k);
    q = wb_dat_o;
    wb_cyc_i <= 0; wb_stb_i <= 0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d); wb(1, a, {24'h0, d}); endtask : wr
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (30000) @(posedge clk_i);
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 6; i++) begin
      wr(ra[i], rw[i]);
      wb(0, ra[i], 0);
      chk("reg", {24'h0, re[i]}, q);
    end
    $display("register rows done");
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 4; i++) begin
      wb(0, ra[i], 0);
      chk("reset reg", (i == 0) ? 32'hff : 32'h0, q);
    end
    wr(8'h08, 8'h20);
    repeat (40) @(posedge clk_i);
    wb(0, 8'h08, 0);
    chk("count held", 32'h20, q);
    wr(8'h04, 8'h01);
    repeat (40) @(posedge clk_i);
    wr(8'h04, 8'h00);
    wb(0, 8'h08, 0);
    chk("count ran", 1, q >= 32'h32 && q <= 32'h38);
    $display("counter test done");
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h03);
    wr(8'h18, 8'h01);
    wr(8'h04, 8'h01);
    n = 0;
    while (irq_o !== 1'b1 && n < 40) begin @(posedge clk_i); n++; end
    chk("irq", 1, irq_o);
    wr(8'h04, 8'h00);
    wb(0, 8'h10, 0);
    chk("match flag", 32'h1, q);
    wr(8'h14, 8'h01);
    repeat (3) @(posedge clk_i);
    chk("irq cleared", 0, irq_o);
    wr(8'h18, 8'h00);
    wr(8'h04, 8'h01);
    repeat (30) @(posedge clk_i);
    chk("irq masked", 0, irq_o);
    wr(8'h04, 8'h00);
    wb(0, 8'h10, 0);
    chk("flag masked", 32'h1, q);
    wr(8'h14, 8'h01);
    wr(8'h08, 8'h05);
    wr(8'h18, 8'h01);
    wr(8'h04, 8'h01);
    repeat (400) @(posedge clk_i);
    chk("no early irq", 0, irq_o);
    n = 0;
    while (irq_o !== 1'b1 && n < 200) begin @(posedge clk_i); n++; end
    chk("wrap irq", 1, irq_o);
    wr(8'h04, 8'h00);
    wr(8'h14, 8'h03);
    $display("timer test done");
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h01);
    wr(8'h04, 8'h01);
    c0 = cbr_cnt;
    repeat (80) @(posedge clk_i);
    chk("refresh count", 1, cbr_cnt - c0 >= 8 && cbr_cnt - c0 <= 11);
    chk("ras width", 2, low_len);
    wb(0, 8'h10, 0);
    chk("done flag", 32'h2, q);
    wr(8'h00, 8'h1d);
    repeat (40) @(posedge clk_i);
    chk("long ras width", 5, low_len);
    wr(8'h00, 8'h01);
    for (int i = 0; i < 5; i++) begin
      bus_busy_i <= !bk[i][2];
      bus_kind_i <= bk[i][1:0];
      page_ras_low_i <= bk[i][2];
      repeat (10) @(posedge clk_i);
      c0 = cbr_cnt;
      repeat (60) @(posedge clk_i);
      chk("overlap", (i == 0 || i == 3), cbr_cnt > c0);
      if (i == 4) chk("ras release", 1, ras_release_o);
      bus_busy_i <= 0;
      page_ras_low_i <= 0;
      c0 = cbr_cnt;
      repeat (20) @(posedge clk_i);
      chk("deferred", 1, cbr_cnt > c0);
    end
    $display("contention test done");
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h03);
    repeat (30) @(posedge clk_i);
    chk("self strobes", 4'h8, {self_refresh_o, dram_ras_n_o, dram_cas_n_o, 1'b0});
    chk("self seen", 1, in_self);
    wr(8'h00, 8'h01);
    repeat (5) @(posedge clk_i);
    chk("self exit", 4'h6, {self_refresh_o, dram_ras_n_o, dram_cas_n_o, 1'b0});
    chk("bad strobes", 0, bad_cnt);
    $display("self refresh test done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
